// *** hdl/gir_station.sv ***
// Purpose: bus station with controller, talker and listener roles
// Assumes: cable lines are active low; open-collector pins split
//          into in, out and enable; 40 MHz local clock
// Notes: received bytes pass an 8-word buffer before the user port
//
// Notes on behaviour
// R1: commands and data share eight lines, 7-bit code
// R2: three-line interlocked handshake paces every byte
// R3: all drive not-ready on commands, listeners on data
// R4: all drive not-accepted on commands, listeners on data
// R5: controller or addressed talker drives data-valid
// R6: controller asserts attention for commands only; here it is also asserted with the end line during parallel poll
// R7: only system controller drives interface clear
// R8: only system controller drives remote enable
// R9: service request any time, handshake independent
// R10: talker marks final byte with end line
// R11: controller uses end line for parallel poll
// R12: all lines negative logic, low is true
// R13: one active controller, handed over to idle one
// R14: only system controller takes control itself
// R15: address talker and listener before data flows
// R16: talk-only and listen-only without a controller
// R17: talker sends data, controller commands to all
// R18: source waits ready, holds until accepted, drops valid
// R19: two-stage sync on every bus input
module gir_station
  import gir_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // user side: role straps and controls
  input wire logic sys_ctrl, // this station is system controller
  input wire logic talk_only, // controller-free sender
  input wire logic listen_only, // controller-free receiver
  input wire logic ctrl_take, // pulse: system controller seizes
  input wire logic ctrl_pass, // pulse: hand control away
  input wire logic ctrl_receive, // pulse: control handed to us
  input wire logic remote_req, // level: request remote mode
  input wire logic poll_req, // level: run a parallel poll
  input wire logic srq_req, // level: request service
  input wire logic addr_talk, // we are addressed as talker
  input wire logic addr_listen, // we are addressed as listener
  input wire logic peers_addressed, // controller has addressed peers
  // user side: byte to send
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [GIR_DATA_W-1:0] tx_data,
  input wire logic tx_cmd, // byte is a command
  input wire logic tx_last, // last byte of message
  // user side: received byte
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [GIR_DATA_W-1:0] rx_data,
  output logic rx_end,
  output logic rx_cmd,
  // status
  output logic cic, // we are active controller
  output logic srq_seen, // service request on the bus
  output logic ifc_seen, // interface clear on the bus
  output logic remote_mode, // bus in remote mode
  // cable pins, low true; oe high while we pull the line
  input wire logic [GIR_DATA_W-1:0] dio_in,
  output logic [GIR_DATA_W-1:0] dio_out,
  output logic [GIR_DATA_W-1:0] dio_oe,
  input wire logic dav_in,
  output logic dav_out,
  output logic dav_oe,
  input wire logic nrfd_in,
  output logic nrfd_out,
  output logic nrfd_oe,
  input wire logic ndac_in,
  output logic ndac_out,
  output logic ndac_oe,
  input wire logic atn_in,
  output logic atn_out,
  output logic atn_oe,
  input wire logic eoi_in,
  output logic eoi_out,
  output logic eoi_oe,
  input wire logic ifc_in,
  output logic ifc_out,
  output logic ifc_oe,
  input wire logic ren_in,
  output logic ren_out,
  output logic ren_oe,
  input wire logic srq_in,
  output logic srq_out,
  output logic srq_oe
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int NS = GIR_DATA_W + 8;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] s1_reg, s2_reg; // first stage feeds second only
  assign raw_in = {dio_in, dav_in, nrfd_in, ndac_in, atn_in,
                   eoi_in, ifc_in, ren_in, srq_in};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_reg <= '1; // idle cable is high
      s2_reg <= '1;
    end else begin
      s1_reg <= raw_in; // [R19]
      s2_reg <= s1_reg; // [R19]
    end
  end
  // true-level views after sync; low on the cable is true [R12]
  logic [GIR_DATA_W-1:0] bus_data;
  logic bus_dav, bus_nrfd, bus_ndac, bus_atn, bus_eoi;
  logic bus_ifc, bus_ren, bus_srq;
  assign bus_data = ~s2_reg[NS-1:8];
  assign bus_dav = (s2_reg[7] == GIR_TRUE);
  assign bus_nrfd = (s2_reg[6] == GIR_TRUE);
  assign bus_ndac = (s2_reg[5] == GIR_TRUE);
  assign bus_atn = (s2_reg[4] == GIR_TRUE);
  assign bus_eoi = (s2_reg[3] == GIR_TRUE);
  assign bus_ifc = (s2_reg[2] == GIR_TRUE);
  assign bus_ren = (s2_reg[1] == GIR_TRUE);
  assign bus_srq = (s2_reg[0] == GIR_TRUE);

  // ****************************************************************
  // controller role
  // ****************************************************************
  logic cic_reg, cic_next; // active controller flag
  logic atn_reg, atn_next; // attention we drive
  logic ifc_reg, ifc_next; // interface clear we drive
  logic ren_reg, ren_next; // remote enable we drive
  logic idy_reg, idy_next; // poll identify on end line
  always_comb begin
    cic_next = cic_reg;
    // only the system controller may seize control [R14]
    if (sys_ctrl && ctrl_take) begin
      cic_next = 1'b1;
    end else if (bus_ifc && !sys_ctrl) begin
      // someone else cleared the bus: lose control [R13]
      // our own clear comes back late through the sync, so the
      // system controller ignores the line, not just its pulse [R7]
      cic_next = 1'b0;
    end else if (ctrl_pass) begin
      cic_next = 1'b0; // hand over to an idle controller [R13]
    end else if (ctrl_receive && !bus_atn) begin
      cic_next = 1'b1; // control received by hand-over [R13]
    end
    // pulse clear while seizing; held one cycle per request [R7]
    ifc_next = sys_ctrl && ctrl_take;
    ren_next = sys_ctrl && remote_req; // [R8]
    // attention while a command byte is queued [R6]
    atn_next = cic_next && tx_valid && tx_cmd && !poll_req;
    // parallel poll: attention with end line [R11]
    idy_next = cic_next && poll_req;
    if (idy_next) begin
      atn_next = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cic_reg <= 1'b0;
      atn_reg <= 1'b0;
      ifc_reg <= 1'b0;
      ren_reg <= 1'b0;
      idy_reg <= 1'b0;
    end else begin
      cic_reg <= cic_next;
      atn_reg <= atn_next;
      ifc_reg <= ifc_next;
      ren_reg <= ren_next;
      idy_reg <= idy_next;
    end
  end

  // ****************************************************************
  // source handshake (talker or controller sending)
  // ****************************************************************
  gir_sh_e sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next; // settle counter
  logic [GIR_DATA_W-1:0] txd_reg, txd_next; // byte on the lines
  logic eom_reg, eom_next; // end mark with final byte
  logic txr_reg, txr_next; // byte taken pulse
  logic can_send;
  // data only when addressed and controller has set up peers [R15]
  assign can_send = tx_cmd ? (cic_reg && atn_reg)
                           : (talk_only || (addr_talk && !bus_atn &&
                              (peers_addressed || !cic_reg))); // [R16]
  always_comb begin
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    txd_next = txd_reg;
    eom_next = eom_reg;
    txr_next = 1'b0;
    unique case (sh_reg)
      GIR_SH_IDLE: begin
        if (tx_valid && can_send && !idy_reg) begin
          txd_next = tx_data; // [R1]
          eom_next = tx_last && !tx_cmd; // [R10]
          sh_next = GIR_SH_WAIT_RFD;
        end
      end
      GIR_SH_WAIT_RFD: begin
        // wait until all acceptors are ready [R18]
        if (!bus_nrfd) begin
          cnt_next = GIR_SETTLE_CNT;
          sh_next = GIR_SH_SETTLE;
        end
      end
      GIR_SH_SETTLE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          sh_next = GIR_SH_VALID;
        end
      end
      GIR_SH_VALID: begin
        // hold byte until every acceptor took it [R2] [R18]
        if (!bus_ndac) begin
          txr_next = 1'b1;
          sh_next = GIR_SH_DROP;
        end
      end
      GIR_SH_DROP: begin
        eom_next = 1'b0;
        sh_next = GIR_SH_IDLE; // valid dropped before next byte [R18]
      end
      default: sh_next = GIR_SH_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sh_reg <= GIR_SH_IDLE;
      cnt_reg <= 4'h0;
      txd_reg <= 8'h00;
      eom_reg <= 1'b0;
      txr_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      txd_reg <= txd_next;
      eom_reg <= eom_next;
      txr_reg <= txr_next;
    end
  end

  // ****************************************************************
  // acceptor handshake (listener, or any station on commands)
  // ****************************************************************
  gir_ah_e ah_reg, ah_next;
  logic take_part; // we drive ready lines this byte
  logic push_v, push_rdy;
  logic [GIR_FIFO_W-1:0] push_w;
  logic [GIR_FIFO_W-1:0] pop_w;
  logic pop_v;
  // everyone on commands, listeners on data [R3] [R4] [R16]
  assign take_part = (bus_atn || addr_listen || listen_only) &&
                     (sh_reg == GIR_SH_IDLE);
  always_comb begin
    ah_next = ah_reg;
    push_v = 1'b0;
    push_w = {bus_eoi && !bus_atn, bus_data}; // [R10]
    unique case (ah_reg)
      GIR_AH_READY: begin
        if (take_part && bus_dav) begin
          ah_next = GIR_AH_TAKE;
        end
      end
      GIR_AH_TAKE: begin
        // store; commands are consumed locally, data buffered
        push_v = !bus_atn;
        if (bus_atn || push_rdy) begin
          ah_next = GIR_AH_WAIT_END; // [R2]
        end
      end
      GIR_AH_WAIT_END: begin
        if (!bus_dav) begin
          ah_next = GIR_AH_READY;
        end
      end
      default: ah_next = GIR_AH_READY;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ah_reg <= GIR_AH_READY;
    end else begin
      ah_reg <= ah_next;
    end
  end

  // receive buffer; full buffer holds ready false on the bus
  gir_fifo #(
    .WIDTH(GIR_FIFO_W),
    .DEPTH(GIR_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_w),
    .out_valid(pop_v),
    .out_ready(rx_ready),
    .out_data(pop_w)
  );

  // ****************************************************************
  // pin drivers, all registered, low true on the cable
  // ****************************************************************
  logic nrfd_d, ndac_d, dav_d, srq_d, eoi_d, rxc_d;
  logic [GIR_DATA_W-1:0] dio_d; // data lines to pull low
  logic [2:0] stat_d; // srq, ifc, ren levels seen
  always_comb begin
    // not ready unless idle and buffer has room [R3]
    nrfd_d = take_part && (ah_next != GIR_AH_READY || !push_rdy);
    // not accepted until byte is stored [R4]
    ndac_d = take_part && (ah_next != GIR_AH_WAIT_END);
    dav_d = (sh_next == GIR_SH_VALID); // [R5] [R17]
    // a one bit pulls its line low while the byte is out [R1] [R12]
    dio_d = (sh_next != GIR_SH_IDLE) ? txd_next : 8'h00;
    eoi_d = (eom_next && dav_d) || idy_next; // [R10] [R11]
    srq_d = srq_req; // no link to the handshake [R9]
    rxc_d = bus_atn;
    stat_d = {bus_srq, bus_ifc, bus_ren};
  end
  logic [4:0] pin_reg; // nrfd, ndac, dav, eoi, srq drive
  logic [GIR_DATA_W-1:0] dio_reg; // data line drive
  logic rxc_reg;
  logic [2:0] stat_reg; // status levels, three flops from the port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_reg <= 5'h00;
      dio_reg <= 8'h00;
      rxc_reg <= 1'b0;
      stat_reg <= 3'h0;
    end else begin
      pin_reg <= {nrfd_d, ndac_d, dav_d, eoi_d, srq_d};
      dio_reg <= dio_d;
      rxc_reg <= rxc_d;
      stat_reg <= stat_d;
    end
  end
  // drive low when true, release otherwise [R12]
  assign nrfd_oe = pin_reg[4];
  assign ndac_oe = pin_reg[3];
  assign dav_oe = pin_reg[2];
  assign dio_oe = dio_reg;
  assign eoi_oe = pin_reg[1];
  assign srq_oe = pin_reg[0];
  assign atn_oe = atn_reg;
  assign ifc_oe = ifc_reg;
  assign ren_oe = ren_reg;
  assign nrfd_out = GIR_TRUE;
  assign ndac_out = GIR_TRUE;
  assign dav_out = GIR_TRUE;
  assign dio_out = '0;
  assign eoi_out = GIR_TRUE;
  assign srq_out = GIR_TRUE;
  assign atn_out = GIR_TRUE;
  assign ifc_out = GIR_TRUE;
  assign ren_out = GIR_TRUE;

  // user outputs
  assign tx_ready = txr_reg;
  assign rx_valid = pop_v;
  assign rx_data = pop_w[GIR_DATA_W-1:0];
  assign rx_end = pop_w[GIR_EOM_BIT];
  assign rx_cmd = rxc_reg;
  assign cic = cic_reg;
  assign srq_seen = stat_reg[2];
  assign ifc_seen = stat_reg[1];
  assign remote_mode = stat_reg[0];
endmodule // gir_station

// *** hdl/gir_pkg.sv ***
// Purpose: shared constants for the instrument bus station
// Assumes: 40 MHz local clock, bus lines active low at the pins
// Notes: times are in ns, counts derived from the clock period
package gir_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int GIR_CLK_PERIOD_NS = 25;
  localparam int GIR_SETTLE_NS = 100; // data settle before valid
  localparam int GIR_SETTLE_CYC =
    (GIR_SETTLE_NS + GIR_CLK_PERIOD_NS - 1) / GIR_CLK_PERIOD_NS;
  localparam logic [3:0] GIR_SETTLE_CNT = 4'(GIR_SETTLE_CYC);
  // ****************************************************************
  // data layout and buffering
  // ****************************************************************
  localparam int GIR_DATA_W = 8;
  localparam int GIR_CHAR_W = 7; // character code width
  localparam int GIR_PAR_BIT = 7; // top bit: spare or parity
  localparam int GIR_FIFO_DEPTH = 8;
  localparam int GIR_FIFO_W = 9; // byte plus end mark
  localparam int GIR_EOM_BIT = 8;
  // ****************************************************************
  // line levels: negative logic on the cable
  // ****************************************************************
  localparam logic GIR_TRUE = 1'b0;
  localparam logic GIR_FALSE = 1'b1;
  // ****************************************************************
  // source handshake states
  // ****************************************************************
  typedef enum logic [2:0] {
    GIR_SH_IDLE,
    GIR_SH_WAIT_RFD,
    GIR_SH_SETTLE,
    GIR_SH_VALID,
    GIR_SH_DROP
  } gir_sh_e;
  // acceptor handshake states
  typedef enum logic [1:0] {
    GIR_AH_READY,
    GIR_AH_TAKE,
    GIR_AH_WAIT_END
  } gir_ah_e;
endpackage : gir_pkg

// *** hdl/gir_fifo.sv ***
// Purpose: small first-in first-out buffer for received bytes
// Assumes: single clock, one push and one pop per cycle at most
// Notes: read data comes from a register, valid when out_valid high
module gir_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // ****************************************************************
  // storage and pointers
  // ****************************************************************
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH]; // word store
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next; // write pointer
  logic [AW-1:0] rd_reg, rd_next; // read pointer
  logic [AW:0] cnt_reg, cnt_next; // words held, incl. output reg
  logic [WIDTH-1:0] dout_reg, dout_next; // registered read data
  logic ov_reg, ov_next; // output register full
  logic push, pop_mem;

  // next state: memory holds words behind the output register
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    dout_next = dout_reg;
    ov_next = ov_reg;
    // honest full: refuse while every slot is taken
    push = in_valid && (cnt_reg != (AW+1)'(DEPTH));
    pop_mem = (cnt_reg > (AW+1)'(ov_reg)) && (!ov_reg || out_ready);
    if (out_valid && out_ready) begin
      ov_next = 1'b0;
    end
    if (pop_mem) begin
      // refill output register from oldest stored word
      dout_next = mem_reg[rd_reg];
      rd_next = rd_reg + 1'b1;
      ov_next = 1'b1;
    end
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = wr_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(out_valid && out_ready);
  end

  // registers only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      dout_reg <= '0;
      ov_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      dout_reg <= dout_next;
      ov_reg <= ov_next;
    end
  end

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = ov_reg;
  assign out_data = dout_reg;
endmodule // gir_fifo

// *** tb/gir_station_sva.sv ***
// Purpose: concurrent checks on the station pins and status
// Assumes: pin enables are high while the station pulls a line low
// Notes: bound into every station; inputs mirror its ports
module gir_station_sva
  import gir_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sys_ctrl,
  input wire logic ctrl_take,
  input wire logic remote_req,
  input wire logic poll_req,
  input wire logic cic,
  input wire logic tx_ready,
  input wire logic [GIR_DATA_W-1:0] dio_oe,
  input wire logic dav_oe,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  input wire logic atn_oe,
  input wire logic eoi_oe,
  input wire logic ifc_oe,
  input wire logic ren_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // handshake and management line checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // valid only after ready has been seen through the synchroniser
  property p_dav_ready;
    $rose(dav_oe) |-> $past(nrfd_in, 3);
  endproperty
  a_dav_ready: assert property (p_dav_ready)
    else $error("valid raised while peers not ready");
  property p_dav_hold;
    dav_oe && !ndac_in |=> dav_oe;
  endproperty
  a_dav_hold: assert property (p_dav_hold)
    else $error("valid dropped before byte accepted");
  property p_dio_stable;
    dav_oe ##1 dav_oe |-> $stable(dio_oe);
  endproperty
  a_dio_stable: assert property (p_dio_stable)
    else $error("data lines moved under valid");
  property p_ready_after;
    tx_ready |-> !dav_oe && $past(ndac_in);
  endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("byte done without acceptance");
  // attention may lag the loss of control by one cycle
  property p_atn_cic;
    atn_oe |-> cic || $past(cic);
  endproperty
  a_atn_cic: assert property (p_atn_cic)
    else $error("attention driven without control");
  property p_ifc_sys;
    ifc_oe |-> sys_ctrl;
  endproperty
  a_ifc_sys: assert property (p_ifc_sys)
    else $error("clear driven by non system station");
  property p_ren_req;
    sys_ctrl && remote_req |-> ##[0:4] ren_oe;
  endproperty
  a_ren_req: assert property (p_ren_req)
    else $error("remote enable not driven");
  property p_poll;
    cic && poll_req |-> ##[0:4] (atn_oe && eoi_oe);
  endproperty
  a_poll: assert property (p_poll)
    else $error("parallel poll lines not driven");
  property p_take;
    sys_ctrl && ctrl_take |-> ##[1:10] cic;
  endproperty
  a_take: assert property (p_take)
    else $error("system controller did not take control");
  c_send: cover property (tx_ready);
  c_take: cover property ($rose(cic));
  c_poll: cover property (atn_oe && eoi_oe);
endmodule // gir_station_sva

bind gir_station gir_station_sva chk (.*);

// *** tb/gir_peer.sv ***
// Purpose: other instruments on the cable: one listener, one talker
// Assumes: lines pulled up; an output high means that line pulled low
// Notes: send is called by the bench; got keeps bytes taken
module gir_peer
  import gir_pkg::*;
(
  input wire logic clk,
  input wire logic acc_en, // act as a receiving station
  input wire logic [7:0] dio_in,
  input wire logic dav_in,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  input wire logic atn_in,
  input wire logic eoi_in,
  output logic [7:0] m_dio = 8'h00,
  output logic m_dav = 1'h0,
  output logic m_nrfd = 1'h0,
  output logic m_ndac = 1'h0,
  output logic m_eoi = 1'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] got[$]; // attention, end, byte as true levels
  logic held = 1'h0; // byte taken, waiting for valid to go false
  // receiver: interlocked, samples once per valid, low is true
  always @(posedge clk) begin
    if (!acc_en) begin
      m_nrfd <= 1'h0;
      m_ndac <= 1'h0;
      held <= 1'h0;
    end else if (!held) begin
      m_nrfd <= !dav_in;
      m_ndac <= dav_in;
      if (!dav_in) begin
        got.push_back({~atn_in, ~eoi_in, ~dio_in});
        held <= 1'h1;
      end
    end else if (dav_in) begin
      m_ndac <= 1'h1;
      held <= 1'h0;
    end
  end
  // sender: wait ready, settle, valid, wait accepted, drop valid
  task automatic send(input logic [7:0] b, input logic last,
                      output bit ok);
    int n;
    n = 0;
    @(posedge clk);
    m_dio <= b;
    m_eoi <= last;
    while (!nrfd_in && n < 60) begin
      @(posedge clk);
      n++;
    end
    ok = nrfd_in;
    if (ok) begin
      repeat (GIR_SETTLE_CYC) @(posedge clk);
      m_dav <= 1'h1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!ndac_in && n < 60);
      ok = ndac_in;
      m_dav <= 1'h0;
    end
    m_dio <= 8'h00; // released lines rise to the pull-up level
    m_eoi <= 1'h0;
  endtask
endmodule // gir_peer

// *** tb/gir_station_test.sv ***
// Purpose: self-checking bench for the instrument bus station
// Assumes: peer model on the cable, wired-and lines with pull-ups
// Notes: inputs change by non-blocking assignment at rising edges
module gir_station_test
  import gir_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, reset = 1, sys_ctrl = 0, talk_only = 0, listen_only = 0;
  logic ctrl_take = 0, ctrl_pass = 0, remote_req = 0, poll_req = 0;
  logic srq_req = 0, tx_valid = 0, tx_cmd = 0, tx_last = 0, rx_ready = 0;
  logic acc_en = 0, addr_talk = 0, peers_addressed = 0;
  logic [1:0] ifc_hit = 2'h0; // clear driven, clear seen
  logic [7:0] tx_data = 8'h00, rx_data, dio_out, dio_oe, m_dio;
  logic tx_ready, rx_valid, rx_end, rx_cmd, cic, srq_seen, ifc_seen;
  logic remote_mode, dav_out, dav_oe, nrfd_out, nrfd_oe, ndac_out, ndac_oe;
  logic atn_out, atn_oe, eoi_out, eoi_oe, ifc_out, ifc_oe, ren_out, ren_oe;
  logic srq_out, srq_oe, m_dav, m_nrfd, m_ndac, m_eoi;
  wire logic [7:0] dio_in;
  wire logic dav_in, nrfd_in, ndac_in, atn_in, eoi_in, ifc_in, ren_in;
  wire logic srq_in;
  int failures = 0, check_count = 0, cycles = 0;
  // ****************************************************************
  // cable: any party pulling makes the line low
  // ****************************************************************
  assign dio_in = ~m_dio & (dio_out | ~dio_oe);
  assign dav_in = ~m_dav & (dav_out | ~dav_oe);
  assign nrfd_in = ~m_nrfd & (nrfd_out | ~nrfd_oe);
  assign ndac_in = ~m_ndac & (ndac_out | ~ndac_oe);
  assign eoi_in = ~m_eoi & (eoi_out | ~eoi_oe);
  assign atn_in = atn_out | ~atn_oe;
  assign ifc_in = ifc_out | ~ifc_oe;
  assign ren_in = ren_out | ~ren_oe;
  assign srq_in = srq_out | ~srq_oe;
  // role inputs not covered here stay false
  gir_station uut (.*, .ctrl_receive(1'h0), .addr_listen(1'h0));
  gir_peer peer (.*);
  initial forever #12.5 clk = ~clk;
  // remembers any clear pulse, which may be short
  always @(posedge clk) ifc_hit <= ifc_hit | {ifc_oe, ifc_seen};
  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one byte through the user port, held until accepted
  task automatic put(input logic [7:0] b, input logic cmd, input logic last);
    int n;
    n = 0;
    @(posedge clk);
    {tx_valid, tx_data, tx_cmd, tx_last} <= {1'h1, b, cmd, last};
    do begin
      @(posedge clk);
      n++;
    end while (tx_ready !== 1'h1 && n < 100);
    chk(tx_ready, 1'h1);
    tx_valid <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_rx();
    int n;
    n = 0;
    wait_cyc(1);
    while (rx_valid !== 1'h1 && n < 80) begin
      wait_cyc(1);
      n++;
    end
    chk(rx_valid, 1'h1);
  endtask
  // one-cycle pulse on take or pass, then time to settle
  task automatic ctl(input logic [1:0] v);
    @(posedge clk);
    {ctrl_take, ctrl_pass} <= v;
    @(posedge clk);
    {ctrl_take, ctrl_pass} <= 2'h0;
    wait_cyc(10);
  endtask
  task automatic t_reset();
    wait_cyc(1);
    chk({dio_oe, dav_oe, atn_oe}, 10'h000);
    chk({cic, tx_ready, rx_valid, ifc_oe, ren_oe, srq_oe, eoi_oe,
         nrfd_oe, ndac_oe}, 10'h000);
  endtask
  // talk-only sender, top bit set in the last byte
  task automatic t_talk();
    @(posedge clk);
    {talk_only, acc_en} <= 2'h3;
    put(8'h41, 1'h0, 1'h0);
    put(8'hC5, 1'h0, 1'h1);
    chk(10'(peer.got.size()), 10'h002);
    chk(peer.got[0], {2'h0, 8'h41});
    chk(peer.got[1], {2'h1, 8'hC5});
    {talk_only, acc_en} <= 2'h0;
    peer.got.delete();
  endtask
  // listen-only: user stalls until the buffer refuses, then drains
  task automatic t_fill();
    bit ok;
    int n;
    @(posedge clk);
    listen_only <= 1'h1;
    wait_cyc(4);
    n = 0;
    ok = 1;
    while (ok && n < 12) begin
      peer.send(8'h30 + 8'(n), n[0], ok);
      if (ok) n++;
    end
    chk(n >= GIR_FIFO_DEPTH, 1'h1);
    chk(n < 12, 1'h1);
    for (int i = 0; i < n; i++) begin
      wait_rx();
      chk({rx_end, rx_data}, {1'(i), 8'h30 + 8'(i)});
      @(posedge clk);
      rx_ready <= 1'h1;
      @(posedge clk);
      rx_ready <= 1'h0;
    end
    wait_cyc(3);
    chk(rx_valid, 1'h0);
    peer.send(8'h7E, 1'h1, ok);
    chk(ok, 1'h1);
    wait_rx();
    chk({rx_end, rx_data}, {1'h1, 8'h7E});
    @(posedge clk);
    {listen_only, rx_ready} <= 2'h1;
  endtask
  // control: refused take, take, command, remote, service, poll, pass
  task automatic t_ctrl();
    @(posedge clk);
    rx_ready <= 1'h0;
    ctl(2'h2);
    chk({cic, ifc_hit}, 3'h0);
    @(posedge clk);
    sys_ctrl <= 1'h1;
    ctl(2'h2);
    chk({cic, ifc_hit}, 3'h7);
    @(posedge clk);
    acc_en <= 1'h1;
    put(8'h3F, 1'h1, 1'h1);
    chk(peer.got[0], {2'h2, 8'h3F});
    wait_cyc(3);
    chk(atn_oe, 1'h0);
    // addressed talker held back until peers are addressed
    @(posedge clk);
    {addr_talk, tx_valid, tx_data, tx_cmd, tx_last} <= {2'h3, 8'h52, 2'h0};
    wait_cyc(8);
    chk({tx_ready, dio_oe}, 9'h000);
    @(posedge clk);
    peers_addressed <= 1'h1;
    put(8'h52, 1'h0, 1'h0);
    chk(peer.got[1], {2'h0, 8'h52});
    @(posedge clk);
    {remote_req, srq_req, poll_req} <= 3'h7;
    wait_cyc(8);
    chk({ren_oe, remote_mode, srq_oe, srq_seen, atn_oe, eoi_oe,
         rx_cmd}, 7'h7F);
    @(posedge clk);
    {remote_req, srq_req, poll_req} <= 3'h0;
    ctl(2'h1);
    chk({cic, atn_oe, ren_oe, srq_oe}, 4'h0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_talk();
    t_fill();
    t_ctrl();
    tally_and_finish();
  end
endmodule // gir_station_test
